//--- rtl/emb_latch_alu.sv
/*
  Port latch modifier: byte write, or one bit rewritten in the old byte.
  Assumes the caller supplies the current latch, never the pin level.
*/
`timescale 1ns/1ps
`default_nettype none

module emb_latch_alu (
  // Old latch byte
  input  wire logic                 [7:0] old_byte,
  // Request
  input  wire emb_pkg::emb_lwr_type       req,
  // Result
  output var  logic                 [7:0] new_byte
);

  // Bit ops rewrite the whole byte with one bit changed
  for (genvar i = 0; i < 8; i++) begin : g_bit
    wire hit = (req.bit_idx == 3'(i));
    wire bit_val = (req.op == emb_pkg::LOP_SET)   ? 1'b1 :
                   (req.op == emb_pkg::LOP_CLEAR) ? 1'b0 : req.carry;
    assign new_byte[i] = (req.op == emb_pkg::LOP_BYTE) ? req.data[i] :
                         hit ? bit_val : old_byte[i]; // see R02
  end

endmodule

`default_nettype wire

//--- rtl/emb_pkg.sv
/*
  Constants and types of the external memory bus port.
  Assumes twelve oscillator periods per machine cycle.
*/
package emb_pkg;

  // Machine cycle framing, in oscillator periods
  localparam logic [3:0]  PH_LAST      = 4'hb;
  localparam logic [3:0]  PH_MID_LAST  = 4'h5;

  // Positions inside one half cycle
  localparam logic [2:0] ALE_H_FIRST  = 3'h1;
  localparam logic [2:0] ALE_H_LAST   = 3'h2;
  localparam logic [2:0] ADDR_H_LAST  = 3'h3;
  localparam logic [2:0] PROGRAM_FETCH_STROBE_H_FIRST = 3'h4;
  localparam logic [2:0] HALF_LAST    = 3'h5;
  localparam logic [2:0] XSTB_H_LAST  = 3'h4;
  localparam logic [2:0] XSAMPLE_H    = 3'h4;
  localparam logic [2:0] FSAMPLE_H    = 3'h5;

  // Latch contents after reset and on every external access
  localparam logic [7:0] LATCH_RESET  = 8'hff;
  localparam logic [7:0] LATCH_ONES   = 8'hff;

  // Strobe port bits that carry the data write and read strobes
  localparam int unsigned WR_BIT = 6;
  localparam int unsigned RD_BIT = 7;

  typedef enum logic [1:0] {
    PORT_LOW,
    PORT_HIGH,
    PORT_STROBE
  } emb_port_type;

  typedef enum logic [2:0] {
    LOP_BYTE,
    LOP_SET,
    LOP_CLEAR,
    LOP_CARRY
  } emb_lop_type;

  typedef enum logic [1:0] {
    ST_INT_FETCH,
    ST_EXT_FETCH,
    ST_XADDR,
    ST_XDATA
  } emb_state_type;

  // External data move request
  typedef struct packed {
    logic        write;
    logic        wide;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } emb_xreq_type;

  // Port latch write request
  typedef struct packed {
    emb_port_type port;
    emb_lop_type  op;
    logic [2:0]   bit_idx;
    logic [7:0]   data;
    logic         carry;
  } emb_lwr_type;

endpackage

//--- rtl/emb_port.sv
/*
  External memory bus port of a small 8-bit core: multiplexed low
  port, high address port, the strobes and the port latches.
  Assumes core requests synchronous to CLK.

// Functional notes
// R01 - Read-modify-write reads take the latch, not pin
// R02 - Bit writes rewrite full latch byte, one bit
// R03 - Fetch strobe for code, read/write for data
// R04 - Fetches 16-bit; data moves 16 or 8 bit
// R05 - Wide address high byte driven whole cycle
// R06 - High latch untouched; pins return after cycle
// R07 - Narrow data moves keep high latch on pins
// R08 - Low port multiplexed, push-pull during accesses
// R09 - Low address valid at strobe falling edge
// R10 - Write data before and after write strobe
// R11 - Read data sampled just before strobe release
// R12 - Every external access sets low latch ones
// R13 - External fetch on select or beyond ROM
// R14 - External execution dedicates high port to address
// R15 - No fetch strobe on internal fetches
// R16 - Fetch strobe twice per cycle except data moves
// R17 - Data read cycle spans twelve oscillator periods
// R18 - Program fetch cycle spans six oscillator periods
// R19 - Address strobe twice every machine cycle
// R20 - Drop first strobe of data move cycle two
// R21 - Strobe disable mode suppresses strobe output
// R22 - Without data moves strobe runs at one sixth
// R23 - Suppress bit kept overridden by external activity
// R24 - Data strobes need latch one, else low
// R25 - After access low port returns to latch
*/
`timescale 1ns/1ps
`default_nettype none

module emb_port #(
  parameter int unsigned OSC_DIV       = 1,
  parameter int unsigned INT_ROM_BYTES = 4096
) (
  // Clock and reset
  input  wire logic                  CLK,
  input  wire logic                  ARST_N,
  // Mode inputs from the core
  input  wire logic                  STROBE_SUPPRESS,
  input  wire logic                  CODE_MOVE,
  // Program fetch
  input  wire logic           [15:0] FETCH_ADDR,
  output var  logic                  FETCH_TAKE,
  output var  logic                  FETCH_EXT,
  output var  logic                  FETCH_VALID,
  output var  logic           [7:0]  FETCH_DATA,
  // External data move
  input  wire logic                  XREQ,
  input  wire emb_pkg::emb_xreq_type XREQ_INFO,
  output var  logic                  XREQ_TAKE,
  output var  logic                  XDONE,
  output var  logic           [7:0]  XRDATA,
  // Port latch write and read
  input  wire logic                  LWR_EN,
  input  wire emb_pkg::emb_lwr_type  LWR,
  input  wire logic                  PRD_REQ,
  input  wire emb_pkg::emb_port_type PRD_PORT,
  input  wire logic                  PRD_LATCH,
  output var  logic                  PRD_VALID,
  output var  logic           [7:0]  PRD_DATA,
  output var  logic           [7:0]  LOW_LATCH,
  output var  logic           [7:0]  HIGH_LATCH,
  output var  logic           [7:0]  STROBE_LATCH,
  // Pins
  input  wire logic                  EXT_ACCESS_SELECT_N,
  input  wire logic           [7:0]  LOW_PORT_IN,
  output var  logic           [7:0]  LOW_PORT_OUT,
  output var  logic           [7:0]  LOW_PORT_OE_N,
  input  wire logic           [7:0]  HIGH_PORT_IN,
  output var  logic           [7:0]  HIGH_PORT_OUT,
  output var  logic           [7:0]  HIGH_PORT_OE_N,
  output var  logic                  ADDR_LATCH_STROBE,
  output var  logic                  ADDR_LATCH_STROBE_OE_N,
  output var  logic                  PROG_FETCH_STROBE_N,
  output var  logic                  DATA_RD_N,
  output var  logic                  DATA_WR_N
);

  if (OSC_DIV < 1 || OSC_DIV > 256) begin : g_bad_div
    $error("OSC_DIV must lie in 1..256");
  end
  if (INT_ROM_BYTES > 65536) begin : g_bad_rom
    $error("INT_ROM_BYTES must not exceed 65536");
  end

  localparam logic [7:0]  DIV_LAST  = 8'(OSC_DIV - 1);
  localparam logic [16:0] ROM_LIMIT = 17'(INT_ROM_BYTES);

  // Synchronised pins
  logic [7:0] low_pin;
  logic [7:0] high_pin;
  logic       ea_n_pin;

  emb_sync #(
    .WIDTH (17)
  ) u_sync (
    .clk    (CLK),
    .arst_n (ARST_N),
    .din    ({EXT_ACCESS_SELECT_N, HIGH_PORT_IN, LOW_PORT_IN}),
    .dout   ({ea_n_pin, high_pin, low_pin})
  );

  // Oscillator period enable and phase counter
  logic [7:0]             osc_cnt;
  logic [3:0]             ph;
  emb_pkg::emb_state_type state;
  emb_pkg::emb_state_type next_state;
  emb_pkg::emb_xreq_type  xreq;
  logic [15:0]            fetch_addr;

  wire       osc_tick  = (osc_cnt == DIV_LAST);
  wire       first_hlf = (ph <= emb_pkg::PH_MID_LAST);
  wire [2:0] half_pos  = first_hlf ? ph[2:0] : 3'(ph - 4'h6);
  wire       half_end  = osc_tick && (half_pos == emb_pkg::HALF_LAST);

  // Bus state decode
  wire st_ext_fetch = (state == emb_pkg::ST_EXT_FETCH);
  wire st_xaddr     = (state == emb_pkg::ST_XADDR);
  wire st_xdata     = (state == emb_pkg::ST_XDATA);
  wire st_xmove     = st_xaddr || st_xdata;

  // Next fetch source: select pin or beyond internal memory
  wire ext_sel  = !ea_n_pin || ({1'b0, FETCH_ADDR} >= ROM_LIMIT); // see R13
  wire xstart   = half_end && first_hlf && XREQ && !st_xmove;
  wire fstart   = half_end && !xstart && !st_xaddr;
  wire bus_open = fstart ? ext_sel : xstart;

  always_comb begin
    next_state = state;
    case (state)
      emb_pkg::ST_XADDR: begin
        next_state = emb_pkg::ST_XDATA;
      end
      emb_pkg::ST_INT_FETCH, emb_pkg::ST_EXT_FETCH,
      emb_pkg::ST_XDATA: begin
        if (xstart) begin
          next_state = emb_pkg::ST_XADDR;
        end else begin
          next_state = ext_sel ? emb_pkg::ST_EXT_FETCH
                               : emb_pkg::ST_INT_FETCH;
        end
      end
      default: begin
        next_state = emb_pkg::ST_INT_FETCH;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      osc_cnt <= 8'h00;
    end else begin
      osc_cnt <= osc_tick ? 8'h00 : 8'(osc_cnt + 8'h01);
    end
  end

  // Six periods a half, twelve a cycle: see R17 see R18 see R22
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ph <= 4'h0;
    end else if (osc_tick) begin
      ph <= (ph == emb_pkg::PH_LAST) ? 4'h0 : 4'(ph + 4'h1);
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state <= emb_pkg::ST_INT_FETCH;
    end else if (half_end) begin
      state <= next_state;
    end
  end

  // Addresses are held for the whole half cycle they belong to
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      fetch_addr <= 16'h0000;
      xreq       <= '0;
    end else begin
      if (fstart) begin
        fetch_addr <= FETCH_ADDR;
      end
      if (xstart) begin
        xreq <= XREQ_INFO;
      end
    end
  end

  // Port latches
  logic [7:0] low_latch;
  logic [7:0] high_latch;
  logic [7:0] strobe_latch;
  logic [7:0] alu_result;

  // Modifier always works on the latch of the addressed port
  wire [7:0] alu_old = (LWR.port == emb_pkg::PORT_LOW)  ? low_latch  :
                       (LWR.port == emb_pkg::PORT_HIGH) ? high_latch :
                       strobe_latch; // see R01

  emb_latch_alu u_alu (
    .old_byte (alu_old),
    .req      (LWR),
    .new_byte (alu_result)
  );

  wire wr_low    = LWR_EN && (LWR.port == emb_pkg::PORT_LOW);
  wire wr_high   = LWR_EN && (LWR.port == emb_pkg::PORT_HIGH);
  wire wr_strobe = LWR_EN && (LWR.port == emb_pkg::PORT_STROBE);

  // Bus access wins over a core write in the same cycle
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      low_latch <= emb_pkg::LATCH_RESET;
    end else if (bus_open) begin
      low_latch <= emb_pkg::LATCH_ONES; // see R12
    end else if (wr_low) begin
      low_latch <= alu_result;
    end
  end

  // Address output never touches the high latch
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      high_latch   <= emb_pkg::LATCH_RESET;
      strobe_latch <= emb_pkg::LATCH_RESET;
    end else begin
      if (wr_high) begin
        high_latch <= alu_result; // see R06
      end
      if (wr_strobe) begin
        strobe_latch <= alu_result;
      end
    end
  end

  // Core port reads: latch for read-modify-write, pins otherwise
  wire [7:0] prd_latch_val = (PRD_PORT == emb_pkg::PORT_LOW)  ? low_latch :
                             (PRD_PORT == emb_pkg::PORT_HIGH) ? high_latch :
                             strobe_latch;
  // Strobe port pins are outputs here, so their read returns the latch
  wire [7:0] prd_pin_val   = (PRD_PORT == emb_pkg::PORT_LOW)  ? low_pin :
                             (PRD_PORT == emb_pkg::PORT_HIGH) ? high_pin :
                             strobe_latch;
  wire [7:0] prd_value     = PRD_LATCH ? prd_latch_val
                                       : prd_pin_val; // see R01

  // Pin decode
  wire addr_slot = (half_pos <= emb_pkg::ADDR_H_LAST);
  wire ale_slot  = (half_pos >= emb_pkg::ALE_H_FIRST) &&
                   (half_pos <= emb_pkg::ALE_H_LAST);
  // Second cycle of a data move has no leading address strobe
  wire ale_level = ale_slot && !st_xdata; // see R19 see R20
  wire ale_force = st_ext_fetch || st_xmove || CODE_MOVE; // see R23
  wire ale_oe    = !STROBE_SUPPRESS || ale_force; // see R21
  wire program_fetch_strobe_on   = st_ext_fetch &&
                   (half_pos >= emb_pkg::PROGRAM_FETCH_STROBE_H_FIRST); // see R15 see R16
  wire xstb_on   = st_xdata && (half_pos <= emb_pkg::XSTB_H_LAST);
  wire rd_on     = xstb_on && !xreq.write; // see R03
  wire wr_on     = xstb_on && xreq.write;

  // Low port: address first, then write data both sides of the strobe
  wire lo_addr   = (st_ext_fetch || st_xaddr) && addr_slot; // see R09
  wire lo_wdata  = xreq.write && ((st_xaddr && !addr_slot) ||
                   st_xdata); // see R10
  wire [7:0] lo_addr_val = st_xaddr ? xreq.addr[7:0] : fetch_addr[7:0];
  wire [7:0] lo_bus_val  = lo_addr ? lo_addr_val : xreq.wdata;
  wire       lo_bus      = lo_addr || lo_wdata; // see R08

  // High port: program counter or wide pointer, else the latch
  wire hi_pc   = st_ext_fetch; // see R14
  wire hi_wide = st_xmove && xreq.wide; // see R04 see R05 see R07
  wire [7:0] hi_bus_val = hi_pc ? fetch_addr[15:8] : xreq.addr[15:8];
  wire       hi_bus     = hi_pc || hi_wide;

  // Strobe pins follow the strobe only while their latch bit is one
  wire rd_pin_n = strobe_latch[emb_pkg::RD_BIT] && !rd_on; // see R24
  wire wr_pin_n = strobe_latch[emb_pkg::WR_BIT] && !wr_on; // see R24

  // Decoded before strobe release; delayed below for the pin sync
  wire fsample = osc_tick && st_ext_fetch &&
                 (half_pos == emb_pkg::FSAMPLE_H);
  wire xsample = osc_tick && st_xdata &&
                 (half_pos == emb_pkg::XSAMPLE_H); // see R11

  // Registered pin outputs
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ADDR_LATCH_STROBE      <= 1'b0;
      ADDR_LATCH_STROBE_OE_N <= 1'b0;
      PROG_FETCH_STROBE_N    <= 1'b1;
      DATA_RD_N              <= 1'b1;
      DATA_WR_N              <= 1'b1;
    end else begin
      ADDR_LATCH_STROBE      <= ale_level;
      ADDR_LATCH_STROBE_OE_N <= !ale_oe;
      PROG_FETCH_STROBE_N    <= !program_fetch_strobe_on;
      DATA_RD_N              <= rd_pin_n;
      DATA_WR_N              <= wr_pin_n;
    end
  end

  // Open-drain when idle: a latch one releases the pin, see R25
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      LOW_PORT_OUT   <= emb_pkg::LATCH_RESET;
      LOW_PORT_OE_N  <= emb_pkg::LATCH_RESET;
      HIGH_PORT_OUT  <= emb_pkg::LATCH_RESET;
      HIGH_PORT_OE_N <= emb_pkg::LATCH_RESET;
    end else begin
      LOW_PORT_OUT   <= lo_bus ? lo_bus_val : low_latch;
      LOW_PORT_OE_N  <= lo_bus ? 8'h00 : low_latch;
      HIGH_PORT_OUT  <= hi_bus ? hi_bus_val : high_latch;
      HIGH_PORT_OE_N <= hi_bus ? 8'h00 : high_latch;
    end
  end

  // Two-clock pin sync: sampling later keeps the byte inside the strobe
  logic [1:0] fs_d;
  logic [1:0] xs_d;

  // Core-facing answers
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      fs_d        <= 2'h0;
      xs_d        <= 2'h0;
      FETCH_TAKE  <= 1'b0;
      FETCH_EXT   <= 1'b0;
      FETCH_VALID <= 1'b0;
      FETCH_DATA  <= 8'h00;
      XREQ_TAKE   <= 1'b0;
      XDONE       <= 1'b0;
      XRDATA      <= 8'h00;
    end else begin
      FETCH_TAKE  <= fstart;
      FETCH_EXT   <= st_ext_fetch;
      fs_d        <= {fs_d[0], fsample};
      xs_d        <= {xs_d[0], xsample};
      FETCH_VALID <= fs_d[1];
      XREQ_TAKE   <= xstart;
      XDONE       <= xs_d[1];
      if (fs_d[1]) begin
        FETCH_DATA <= low_pin;
      end
      if (xs_d[1] && !xreq.write) begin
        XRDATA <= low_pin;
      end
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      PRD_VALID    <= 1'b0;
      PRD_DATA     <= 8'h00;
      LOW_LATCH    <= emb_pkg::LATCH_RESET;
      HIGH_LATCH   <= emb_pkg::LATCH_RESET;
      STROBE_LATCH <= emb_pkg::LATCH_RESET;
    end else begin
      PRD_VALID    <= PRD_REQ;
      LOW_LATCH    <= low_latch;
      HIGH_LATCH   <= high_latch;
      STROBE_LATCH <= strobe_latch;
      if (PRD_REQ) begin
        PRD_DATA <= prd_value;
      end
    end
  end

endmodule

`default_nettype wire

//--- rtl/emb_sync.sv
/*
  Two flip-flop synchroniser for a bundle of pin levels.
  Assumes each bit is an independent level; no word coherence is given.
*/
`timescale 1ns/1ps
`default_nettype none

module emb_sync #(
  parameter int unsigned WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             arst_n,
  // Levels
  input  wire logic [WIDTH-1:0] din,
  output var  logic [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] stage;

  // First stage is read by the second stage only
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stage <= '0;
      dout  <= '0;
    end else begin
      stage <= din;
      dout  <= stage;
    end
  end

endmodule

`default_nettype wire

//--- verif/emb_mem_model.sv
/*
  External memory with its address latch, behind the low port.
  Assumes it resolves the low port wire from the port enables.
*/
`timescale 1ns/1ps
`default_nettype none

module emb_mem_model (
  // Strobes
  input  wire logic       ale,
  input  wire logic       program_fetch_strobe_n,
  input  wire logic       rd_n,
  input  wire logic       wr_n,
  // Low address/data wire
  input  wire logic [7:0] lo_out,
  input  wire logic [7:0] lo_oe_n,
  output var  logic [7:0] lo_in
);
  logic [7:0] mem [256];
  logic [7:0] addr;
  logic [7:0] last;
  logic       reading;

  // Code and data share one array, like a combined memory
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = ~8'(i);
    addr = 8'h00;
    last = 8'h00;
  end
  assign reading = !program_fetch_strobe_n || !rd_n;
  // Floating wire shows the inverse of the last byte, never a stale copy
  assign lo_in = (lo_out & ~lo_oe_n)
               | ((reading ? mem[addr] : ~last) & lo_oe_n);
  always @(negedge ale) addr <= lo_in;
  always @(posedge wr_n) mem[addr] <= lo_in;
  always @(posedge program_fetch_strobe_n or posedge rd_n) last <= mem[addr];
endmodule

`default_nettype wire

//--- verif/emb_port_asserts.sv
/*
  Pin-level assertions for emb_port, attached by bind.
  Assumes OSC_DIV of 1, so one oscillator period is one clock.
*/
`timescale 1ns/1ps
`default_nettype none

module emb_port_asserts #(
  parameter int unsigned OSC_DIV       = 1,
  parameter int unsigned INT_ROM_BYTES = 4096
) (
  // Clock and reset
  input wire logic                  CLK,
  input wire logic                  ARST_N,
  // Data move
  input wire emb_pkg::emb_xreq_type XREQ_INFO,
  input wire logic                  XREQ_TAKE,
  input wire logic                  XDONE,
  // Latch copies
  input wire logic [7:0]            LOW_LATCH,
  input wire logic [7:0]            HIGH_LATCH,
  input wire logic [7:0]            STROBE_LATCH,
  // Pins
  input wire logic [7:0]            LOW_PORT_OUT,
  input wire logic [7:0]            LOW_PORT_OE_N,
  input wire logic [7:0]            HIGH_PORT_OUT,
  input wire logic [7:0]            HIGH_PORT_OE_N,
  input wire logic                  ADDR_LATCH_STROBE,
  input wire logic                  PROG_FETCH_STROBE_N,
  input wire logic                  DATA_RD_N,
  input wire logic                  DATA_WR_N
);
  wire logic       ale = ADDR_LATCH_STROBE;
  wire logic [7:0] wd  = XREQ_INFO.wdata;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);

  sequence s_rd_low;
    $fell(DATA_RD_N) ##1 (!DATA_RD_N)[*4] ##1 DATA_RD_N;
  endsequence
  sequence s_wr_end;
    ##5 ($rose(DATA_WR_N) && LOW_PORT_OE_N == 8'h00 && LOW_PORT_OUT == wd);
  endsequence

  property p_ale_width;
    $rose(ale) |=> ale ##1 !ale;
  endproperty
  property p_ale_gap;
    $rose(ale) |=> (!$rose(ale))[*5];
  endproperty
  property p_ale_drop;
    XREQ_TAKE |-> ##[1:8] $rose(ale) ##1 (!$rose(ale))[*8];
  endproperty
  property p_strobe_excl;
    !(!DATA_RD_N && !PROG_FETCH_STROBE_N);
  endproperty
  property p_fetch_pulse;
    $fell(PROG_FETCH_STROBE_N) |-> (HIGH_PORT_OE_N == 8'h00)
      ##1 !PROG_FETCH_STROBE_N ##1 PROG_FETCH_STROBE_N;
  endproperty
  property p_wr_data;
    $fell(DATA_WR_N) |-> (LOW_PORT_OE_N == 8'h00 && $stable(LOW_PORT_OUT)
      && LOW_PORT_OUT == wd) ##0 s_wr_end;
  endproperty
  property p_rd_cycle;
    XREQ_TAKE && !XREQ_INFO.write && STROBE_LATCH[7] |-> ##[4:9] s_rd_low;
  endproperty
  property p_done;
    XREQ_TAKE |=> (!XDONE)[*8] ##[2:6] XDONE;
  endproperty
  property p_low_ones;
    XREQ_TAKE |-> ##[1:12] (LOW_LATCH == emb_pkg::LATCH_ONES);
  endproperty
  property p_rd_gated;
    !STROBE_LATCH[7] && $stable(STROBE_LATCH) |-> !DATA_RD_N;
  endproperty
  property p_high_wide;
    XREQ_TAKE && XREQ_INFO.wide |-> ##2 (HIGH_PORT_OE_N == 8'h00
      && HIGH_PORT_OUT == XREQ_INFO.addr[15:8])[*8];
  endproperty
  property p_high_narrow;
    XREQ_TAKE && !XREQ_INFO.wide |-> ##2 (HIGH_PORT_OUT == HIGH_LATCH)[*8];
  endproperty

  a_ale_width: assert property (p_ale_width)
    else $error("strobe width wrong");
  a_ale_gap: assert property (p_ale_gap)
    else $error("strobe pulses too close");
  a_ale_drop: assert property (p_ale_drop)
    else $error("strobe pulse not dropped");
  a_strobe_excl: assert property (p_strobe_excl)
    else $error("fetch and read strobes overlap");
  a_fetch_pulse: assert property (p_fetch_pulse)
    else $error("fetch strobe shape wrong");
  a_wr_data: assert property (p_wr_data)
    else $error("write data not around strobe");
  a_rd_cycle: assert property (p_rd_cycle)
    else $error("read strobe shape wrong");
  a_done: assert property (p_done)
    else $error("data move length wrong");
  a_low_ones: assert property (p_low_ones)
    else $error("low latch not set to ones");
  a_rd_gated: assert property (p_rd_gated)
    else $error("read pin not held low");
  a_high_wide: assert property (p_high_wide)
    else $error("high address byte missing");
  a_high_narrow: assert property (p_high_narrow)
    else $error("high latch not on pins");
endmodule

bind emb_port emb_port_asserts #(
  .OSC_DIV(OSC_DIV), .INT_ROM_BYTES(INT_ROM_BYTES)
) u_asserts (.*);

`default_nettype wire

//--- verif/test_external_memory_bus_port.sv
/*
  Self-checking bench for emb_port with the memory model.
  Assumes OSC_DIV of 1 and a 250 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none

module test_external_memory_bus_port;
  logic        clk, arst_n, strobe_suppress, code_move, ext_sel_n;
  logic        fetch_take, fetch_ext, fetch_valid, xreq, xreq_take;
  logic        xdone, lwr_en, prd_req, prd_latch, prd_valid;
  logic        ale, ale_oe_n, program_fetch_strobe_n, rd_n, wr_n;
  logic [15:0] fetch_addr;
  logic [7:0]  fetch_data, xrdata, prd_data, low_latch, high_latch;
  logic [7:0]  strobe_latch, low_in, low_out, low_oe_n, high_in;
  logic [7:0]  high_out, high_oe_n, ext_low;
  emb_pkg::emb_xreq_type xreq_info;
  emb_pkg::emb_lwr_type  lwr;
  emb_pkg::emb_port_type prd_port;
  int          errors, samples_checked;

  // Pull-ups on the high port; ext_low is a part pulling pins down
  assign high_in = (high_out | high_oe_n) & ~ext_low;

  emb_port #(.OSC_DIV(1), .INT_ROM_BYTES(4096)) uut (
    .CLK(clk), .ARST_N(arst_n), .STROBE_SUPPRESS(strobe_suppress),
    .CODE_MOVE(code_move), .FETCH_ADDR(fetch_addr),
    .FETCH_TAKE(fetch_take), .FETCH_EXT(fetch_ext),
    .FETCH_VALID(fetch_valid), .FETCH_DATA(fetch_data), .XREQ(xreq),
    .XREQ_INFO(xreq_info), .XREQ_TAKE(xreq_take), .XDONE(xdone),
    .XRDATA(xrdata), .LWR_EN(lwr_en), .LWR(lwr), .PRD_REQ(prd_req),
    .PRD_PORT(prd_port), .PRD_LATCH(prd_latch), .PRD_VALID(prd_valid),
    .PRD_DATA(prd_data), .LOW_LATCH(low_latch), .HIGH_LATCH(high_latch),
    .STROBE_LATCH(strobe_latch), .EXT_ACCESS_SELECT_N(ext_sel_n),
    .LOW_PORT_IN(low_in), .LOW_PORT_OUT(low_out),
    .LOW_PORT_OE_N(low_oe_n), .HIGH_PORT_IN(high_in),
    .HIGH_PORT_OUT(high_out), .HIGH_PORT_OE_N(high_oe_n),
    .ADDR_LATCH_STROBE(ale), .ADDR_LATCH_STROBE_OE_N(ale_oe_n),
    .PROG_FETCH_STROBE_N(program_fetch_strobe_n), .DATA_RD_N(rd_n), .DATA_WR_N(wr_n)
  );

  emb_mem_model u_mem (
    .ale(ale), .program_fetch_strobe_n(program_fetch_strobe_n), .rd_n(rd_n), .wr_n(wr_n),
    .lo_out(low_out), .lo_oe_n(low_oe_n), .lo_in(low_in)
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Bounded wait; a hang counts as a mismatch
  task automatic wait_lv(ref logic s, input logic v);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (s !== v && n < 64);
    if (n == 64) chk(8'h01, 8'h00);
  endtask

  task automatic watch(input int n, output int a, output int p,
                       output int h);
    logic pa, pp;
    a = 0;
    p = 0;
    h = 0;
    pa = ale;
    pp = program_fetch_strobe_n;
    repeat (n) begin
      @(posedge clk);
      a += int'(ale && !pa);
      p += int'(!program_fetch_strobe_n && pp);
      h += int'(ale_oe_n);
      pa = ale;
      pp = program_fetch_strobe_n;
    end
  endtask

  task automatic lwr_op(input emb_pkg::emb_port_type pt,
                        input emb_pkg::emb_lop_type op,
                        input logic [2:0] b, input logic c,
                        input logic [7:0] d = 8'h00);
    lwr <= '{port: pt, op: op, bit_idx: b, data: d, carry: c};
    lwr_en <= 1'b1;
    @(posedge clk);
    lwr_en <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  task automatic xmove(input logic w, input logic wide,
                       input logic [15:0] a, input logic [7:0] d, exp);
    xreq_info <= '{write: w, wide: wide, addr: a, wdata: d};
    xreq <= 1'b1;
    wait_lv(xreq_take, 1'b1);
    xreq <= 1'b0;
    wait_lv(xdone, 1'b1);
    if (!w) chk(xrdata, exp);
    repeat (8) @(posedge clk);
    chk(low_oe_n, 8'hff);
    chk(low_latch, 8'hff);
  endtask

  task automatic t_fetch();
    int a, p, h;
    repeat (12) @(posedge clk);
    watch(24, a, p, h);
    chk(8'(p), 8'h00);
    chk(8'(a), 8'h04);
    chk(8'(h), 8'h00);
    fetch_addr <= 16'h1234;
    repeat (12) @(posedge clk);
    wait_lv(program_fetch_strobe_n, 1'b0);
    chk(high_out, 8'h12);
    watch(24, a, p, h);
    chk(8'(p), 8'h04);
    chk(8'(a), 8'h04);
    wait_lv(fetch_valid, 1'b1);
    chk(fetch_data, 8'hcb);
    fetch_addr <= 16'h0020;
    ext_sel_n <= 1'b0;
    repeat (12) @(posedge clk);
    wait_lv(fetch_valid, 1'b1);
    chk(fetch_data, 8'hdf);
    ext_sel_n <= 1'b1;
    $display("fetch test done");
  endtask

  task automatic t_latch();
    lwr_op(emb_pkg::PORT_HIGH, emb_pkg::LOP_BYTE, 3'h0, 1'b0, 8'h5a);
    chk(high_latch, 8'h5a);
    lwr_op(emb_pkg::PORT_HIGH, emb_pkg::LOP_SET, 3'h0, 1'b0);
    chk(high_latch, 8'h5b);
    lwr_op(emb_pkg::PORT_HIGH, emb_pkg::LOP_CLEAR, 3'h3, 1'b0);
    chk(high_latch, 8'h53);
    lwr_op(emb_pkg::PORT_HIGH, emb_pkg::LOP_CARRY, 3'h7, 1'b1);
    chk(high_latch, 8'hd3);
    ext_low <= 8'hff;
    prd_port <= emb_pkg::PORT_HIGH;
    for (int i = 1; i >= 0; i--) begin
      prd_latch <= 1'(i);
      prd_req <= 1'b1;
      @(posedge clk);
      prd_req <= 1'b0;
      repeat (4) @(posedge clk);
      chk(prd_data, i == 1 ? 8'hd3 : 8'h00);
    end
    ext_low <= 8'h00;
    $display("latch test done");
  endtask

  task automatic t_move();
    lwr_op(emb_pkg::PORT_LOW, emb_pkg::LOP_BYTE, 3'h0, 1'b0);
    chk(low_oe_n, 8'h00);
    xmove(1'b1, 1'b1, 16'h3456, 8'ha5, 8'h00);
    chk(high_latch, 8'hd3);
    xmove(1'b0, 1'b0, 16'h0056, 8'h00, 8'ha5);
    xmove(1'b0, 1'b1, 16'h7701, 8'h00, 8'hfe);
    lwr_op(emb_pkg::PORT_STROBE, emb_pkg::LOP_CLEAR, 3'h7, 1'b0);
    chk(8'(rd_n), 8'h00);
    lwr_op(emb_pkg::PORT_STROBE, emb_pkg::LOP_SET, 3'h7, 1'b0);
    chk(8'(rd_n), 8'h01);
    $display("data move test done");
  endtask

  task automatic t_suppress();
    int a, p, h;
    strobe_suppress <= 1'b1;
    repeat (4) @(posedge clk);
    watch(12, a, p, h);
    chk(8'(h), 8'h0c);
    code_move <= 1'b1;
    repeat (4) @(posedge clk);
    watch(12, a, p, h);
    chk(8'(h), 8'h00);
    code_move <= 1'b0;
    ext_sel_n <= 1'b0;
    repeat (12) @(posedge clk);
    watch(12, a, p, h);
    chk(8'(h), 8'h00);
    strobe_suppress <= 1'b0;
    ext_sel_n <= 1'b1;
    $display("suppress test done");
  endtask

  initial begin
    arst_n = 1'b0;
    strobe_suppress = 1'b0;
    code_move = 1'b0;
    ext_sel_n = 1'b1;
    fetch_addr = 16'h0010;
    xreq = 1'b0;
    xreq_info = '0;
    lwr_en = 1'b0;
    lwr = '0;
    prd_req = 1'b0;
    prd_port = emb_pkg::PORT_LOW;
    prd_latch = 1'b0;
    ext_low = 8'h00;
    errors = 0;
    samples_checked = 0;
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    t_fetch();
    t_latch();
    t_move();
    t_suppress();
    results();
  end

  // Wide margin over the expected run
  initial begin
    #20000;
    errors++;
    results();
  end
endmodule

`default_nettype wire
